// *** hdl/cst_sequencer.sv ***
// Command sequencer: picks sequences per instruction and runs the phase chain.
// Assumes memory answers within a phase; readData is valid at 2.2.
`timescale 1ns/100ps
module cst_sequencer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [17:0] readData,
  input wire logic [14:0] operandAddr,
  input wire logic [17:0] accumulatorLower,
  input wire logic [17:0] resultData,
  output cst_pkg::cst_seq_e activeSeq,
  output cst_pkg::cst_time_s phaseTime,
  output logic phaseTick,
  output logic [17:0] memoryReadBuffer,
  output logic [17:0] arithSelector,
  output logic [14:0] memAddr,
  output logic memRead,
  output logic memWrite,
  output logic [17:0] memWriteData,
  output logic ctrlMemWrite,
  output logic [17:0] ctrlMemData,
  output logic channelActive,
  output logic instrDone
);
  import cst_pkg::*;

  logic [3:0] phase;
  logic [14:0] progCount;
  logic [1:0] seqIndex;
  cst_plan_s plan;
  cst_plan_s decoded;
  logic lastPhase;
  cst_seq_e next_seq;

  cst_decode u_decode (
    .major(memoryReadBuffer[17:12]),
    .minor(memoryReadBuffer[11:6]),
    .plan(decoded)
  );

  assign lastPhase = (phase == CST_PHASE_LAST);

  // Phase index 15 is 4.4; it wraps to 0 (1.1) and ends at 14 (4.3).
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= CST_PHASE_START;
      phaseTick <= 1'b0;
    end else if (run) begin
      phase <= phase + 4'h1;
      phaseTick <= 1'b1;
    end else begin
      phaseTick <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phaseTime <= cst_time_s'(CST_PHASE_START);
    end else if (run) begin
      phaseTime <= '{cycle: 2'(phase + 4'h1 >> 2), phase: 2'(phase + 4'h1)};
    end
  end

  always_comb begin
    next_seq = CST_SEQ_FETCH;
    if (activeSeq == CST_SEQ_FETCH) begin
      next_seq = (plan.s1 == CST_SEQ_NONE) ? CST_SEQ_FETCH : plan.s1;
    end else if (seqIndex == 2'd1 && plan.s2 != CST_SEQ_NONE) begin
      next_seq = plan.s2;
    end
  end

  // Sequences change only at the end of 4.3, so each starts at 4.4.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      activeSeq <= CST_SEQ_FETCH;
      seqIndex <= 2'd0;
      instrDone <= 1'b0;
    end else begin
      instrDone <= 1'b0;
      if (run && lastPhase) begin
        activeSeq <= next_seq;
        seqIndex <= (next_seq == CST_SEQ_FETCH) ? 2'd0 : seqIndex + 2'd1;
        instrDone <= (next_seq == CST_SEQ_FETCH);
      end
    end
  end

  // The plan is latched at 3.3 of fetch so later buffer loads cannot disturb it.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      plan <= '{s1: CST_SEQ_NONE, s2: CST_SEQ_NONE};
    end else if (run && activeSeq == CST_SEQ_FETCH && phase == CST_PHASE_3_3) begin
      plan <= decoded;
    end
  end

  // Unconditional fetch load at 2.2; conditional commands gate on code.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      memoryReadBuffer <= CST_WORD_RESET;
    end else if (run && phase == CST_PHASE_2_2 && activeSeq != CST_SEQ_WRITE && activeSeq != CST_SEQ_EXT
        && activeSeq != CST_SEQ_NONE) begin
      memoryReadBuffer <= readData;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      arithSelector <= CST_WORD_RESET;
    end else if (run && activeSeq == CST_SEQ_FETCH && phase == CST_PHASE_3_3
        && memoryReadBuffer[17:12] == CST_CODE_71) begin
      arithSelector <= accumulatorLower;
    end
  end

  // Program counter advances once per memory word consumed by fetch or buffer.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      progCount <= CST_ADDR_RESET;
    end else if (run && phase == CST_PHASE_4_2 && (activeSeq == CST_SEQ_FETCH
        || activeSeq == CST_SEQ_BUF1 || activeSeq == CST_SEQ_BUF2)) begin
      progCount <= progCount + 15'h0001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      memAddr <= CST_ADDR_RESET;
      memRead <= 1'b0;
      memWrite <= 1'b0;
      memWriteData <= CST_WORD_RESET;
    end else begin
      memRead <= 1'b0;
      memWrite <= 1'b0;
      if (run && phase == CST_PHASE_START) begin
        unique case (activeSeq)
          CST_SEQ_FETCH, CST_SEQ_BUF1, CST_SEQ_BUF2: begin
            memAddr <= progCount;
            memRead <= 1'b1;
          end
          CST_SEQ_READ1, CST_SEQ_READ2: begin
            memAddr <= operandAddr;
            memRead <= 1'b1;
          end
          CST_SEQ_WRITE: begin
            memAddr <= operandAddr;
            memWrite <= 1'b1;
            memWriteData <= resultData;
          end
          CST_SEQ_EXT, CST_SEQ_NONE: begin
            memRead <= 1'b0;
          end
        endcase
      end
    end
  end

  // Buffer words go to control memory at 4.2; the second also arms the channel.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlMemWrite <= 1'b0;
      ctrlMemData <= CST_WORD_RESET;
      channelActive <= 1'b0;
    end else begin
      ctrlMemWrite <= 1'b0;
      if (run && phase == CST_PHASE_4_2
          && (activeSeq == CST_SEQ_BUF1 || activeSeq == CST_SEQ_BUF2)) begin
        ctrlMemWrite <= 1'b1;
        ctrlMemData <= memoryReadBuffer;
        if (activeSeq == CST_SEQ_BUF2) begin
          channelActive <= 1'b1;
        end
      end
    end
  end
endmodule

// *** hdl/cst_pkg.sv ***
// Constants and carrier types of the command sequence timing block.
// Assumes one 125 MHz clock; memory handshakes are the caller's concern.
package cst_pkg;
  typedef enum logic [2:0] {
    CST_SEQ_FETCH,
    CST_SEQ_READ1,
    CST_SEQ_READ2,
    CST_SEQ_WRITE,
    CST_SEQ_BUF1,
    CST_SEQ_BUF2,
    CST_SEQ_EXT,
    CST_SEQ_NONE
  } cst_seq_e;

  typedef struct packed {
    cst_seq_e s1;
    cst_seq_e s2;
  } cst_plan_s;

  typedef struct packed {
    logic [1:0] cycle;
    logic [1:0] phase;
  } cst_time_s;

  localparam logic [5:0] CST_MAJOR_EXT = 6'h28;
  localparam logic [5:0] CST_CODE_71 = 6'h39;
  localparam logic [3:0] CST_PHASE_START = 4'hF;
  localparam logic [3:0] CST_PHASE_LAST = 4'hE;
  localparam logic [3:0] CST_PHASE_2_2 = 4'h5;
  localparam logic [3:0] CST_PHASE_3_3 = 4'hA;
  localparam logic [3:0] CST_PHASE_4_2 = 4'hD;
  localparam logic [17:0] CST_WORD_RESET = 18'h00000;
  localparam logic [14:0] CST_ADDR_RESET = 15'h0000;
endpackage

// *** hdl/cst_decode.sv ***
// Instruction code to sequence plan translator.
// Assumes a stable code for the cycle it is sampled in.
`timescale 1ns/100ps
module cst_decode (
  input wire logic [5:0] major,
  input wire logic [5:0] minor,
  output cst_pkg::cst_plan_s plan
);
  import cst_pkg::*;

  always_comb begin
    plan = '{s1: CST_SEQ_NONE, s2: CST_SEQ_NONE};
    if (major == CST_MAJOR_EXT) begin
      if (minor >= 6'o10 && minor <= 6'o13) begin
        plan = '{s1: CST_SEQ_BUF1, s2: CST_SEQ_BUF2};
      end else if (minor == 6'o44) begin
        plan = '{s1: CST_SEQ_EXT, s2: CST_SEQ_WRITE};
      end else if (minor >= 6'o41 && minor <= 6'o47) begin
        plan = '{s1: CST_SEQ_EXT, s2: CST_SEQ_NONE};
      end
      // Remaining subcodes complete in fetch alone.
    end else begin
      if ((major >= 6'o02 && major <= 6'o17) || major == 6'o32 || major == 6'o33
          || (major >= 6'o51 && major <= 6'o56)) begin
        plan = '{s1: CST_SEQ_READ1, s2: CST_SEQ_NONE};
      end else if (major >= 6'o20 && major <= 6'o23) begin
        plan = '{s1: CST_SEQ_READ1, s2: CST_SEQ_READ2};
      end else if (major >= 6'o24 && major <= 6'o27) begin
        plan = '{s1: CST_SEQ_READ1, s2: CST_SEQ_EXT};
      end else if ((major >= 6'o40 && major <= 6'o47) || major == 6'o72
          || (major >= 6'o74 && major <= 6'o76)) begin
        plan = '{s1: CST_SEQ_WRITE, s2: CST_SEQ_NONE};
      end
      // Others, including 00, 01, 34, 35, 60-71, 73 and 77, end after fetch.
    end
  end
endmodule

// *** testbench/cst_sequencer_asserts.sv ***
// Port checks for the command sequencer.
// Assumes one clock mclk and an asynchronous low reset rst_n.
`timescale 1ns/100ps
module cst_sequencer_asserts import cst_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [17:0] readData,
  input wire logic [17:0] accumulatorLower,
  input wire logic [17:0] resultData,
  input cst_pkg::cst_seq_e activeSeq,
  input cst_pkg::cst_time_s phaseTime,
  input wire logic [17:0] memoryReadBuffer,
  input wire logic [17:0] arithSelector,
  input wire logic memRead,
  input wire logic memWrite,
  input wire logic [17:0] memWriteData,
  input wire logic instrDone
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence fetch_at(logic [3:0] p);
    activeSeq == CST_SEQ_FETCH && phaseTime == p && run;
  endsequence
  phase_step_a: assert property ($past(run) |-> phaseTime == 4'($past(phaseTime) + 4'h1))
    else $error("Phase did not step by one.");
  chain_freeze_a: assert property (!$past(run) |-> $stable(phaseTime) && $stable(activeSeq))
    else $error("Chain moved while stopped.");
  seq_hold_a: assert property (!($past(run) && $past(phaseTime) == CST_PHASE_LAST) |-> $stable(activeSeq))
    else $error("Sequence changed mid sequence.");
  done_fetch_a: assert property (instrDone |-> ##[0:1] (activeSeq == CST_SEQ_FETCH && phaseTime == CST_PHASE_START))
    else $error("No fetch after instruction end.");
  read_issue_a: assert property (memRead |-> $past(phaseTime) == CST_PHASE_START && !memWrite)
    else $error("Read issued off the start phase.");
  write_data_a: assert property (memWrite |-> activeSeq == CST_SEQ_WRITE && memWriteData == resultData)
    else $error("Bad write request.");
  load_mrb_a: assert property (fetch_at(CST_PHASE_2_2) |=> memoryReadBuffer == $past(readData))
    else $error("Read buffer not loaded.");
  route_al_a: assert property (fetch_at(CST_PHASE_3_3) ##0 memoryReadBuffer[17:12] == CST_CODE_71
    |=> arithSelector == $past(accumulatorLower)) else $error("Lower accumulator not routed.");
endmodule
bind cst_sequencer cst_sequencer_asserts u_chk (.*);

// *** testbench/cst_mem_model.sv ***
// Core memory model answering read requests from a word image.
// Data is held a few cycles after a request, then scrambled every cycle.
`timescale 1ns/100ps
module cst_mem_model (
  input wire logic mclk,
  input wire logic memRead,
  input wire logic [14:0] memAddr,
  input wire logic [17:0] image [0:31],
  output logic [17:0] readData = 18'h15555
);
  logic [2:0] age = 3'h7;
  always @(posedge mclk) begin
    if (memRead) begin
      readData <= image[memAddr[4:0]];
      age <= 3'h0;
    end else if (age != 3'h7) begin
      age <= age + 3'h1;
    end else begin
      readData <= ~readData;
    end
  end
endmodule

// *** testbench/tb_top.sv ***
// Bench running a short instruction program through the sequencer.
// Assumes the memory model serves fetch and operand reads from one image.
`timescale 1ns/100ps
module tb_top;
  import cst_pkg::*;
  logic mclk, rst_n, run, phaseTick, memRead, memWrite, ctrlMemWrite, channelActive, instrDone;
  logic [17:0] readData, accumulatorLower, resultData, memoryReadBuffer, arithSelector, memWriteData, ctrlMemData;
  logic [14:0] operandAddr, memAddr;
  logic [17:0] image [0:31];
  cst_seq_e activeSeq;
  cst_time_s phaseTime;
  cst_seq_e seen[$];
  logic [17:0] ctrl[$];
  logic [14:0] wr[$];
  int errors = 0;
  int checks = 0;
  cst_sequencer dut (.*);
  cst_mem_model mem (.mclk(mclk), .memRead(memRead), .memAddr(memAddr), .image(image), .readData(readData));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Samples the sequence in mid flight so small offsets at the boundaries do not matter.
  task automatic run_instr(input cst_seq_e a, input cst_seq_e b, input cst_seq_e c, input int n);
    cst_seq_e want[3] = '{a, b, c};
    int k = 0;
    seen.delete();
    ctrl.delete();
    wr.delete();
    do begin
      @(posedge mclk);
      #1;
      k++;
      if (k % 16 == 8) seen.push_back(activeSeq);
      if (ctrlMemWrite === 1'b1) ctrl.push_back(ctrlMemData);
      if (memWrite === 1'b1) wr.push_back(memAddr);
    end while (instrDone !== 1'b1 && k < 64);
    check(18'(seen.size()), 18'(n));
    for (int i = 0; i < n; i++) check(18'(seen[i]), 18'(want[i]));
  endtask
  task automatic test_fetch_only();
    run_instr(CST_SEQ_FETCH, CST_SEQ_NONE, CST_SEQ_NONE, 1);
    run_instr(CST_SEQ_FETCH, CST_SEQ_NONE, CST_SEQ_NONE, 1);
    check(memoryReadBuffer, image[1]);
    check(arithSelector, accumulatorLower);
    check(18'(phaseTick), 18'h00001);
  endtask
  task automatic test_reads();
    run_instr(CST_SEQ_FETCH, CST_SEQ_READ1, CST_SEQ_NONE, 2);
    run_instr(CST_SEQ_FETCH, CST_SEQ_READ1, CST_SEQ_EXT, 3);
    run_instr(CST_SEQ_FETCH, CST_SEQ_READ1, CST_SEQ_READ2, 3);
    check(memoryReadBuffer, image[16]);
  endtask
  task automatic test_writes();
    run_instr(CST_SEQ_FETCH, CST_SEQ_WRITE, CST_SEQ_NONE, 2);
    check(18'(wr.size()), 18'h00001);
    check(18'(wr[0]), 18'(operandAddr));
    run_instr(CST_SEQ_FETCH, CST_SEQ_EXT, CST_SEQ_NONE, 2);
    check(18'(wr.size()), 18'h00000);
    run_instr(CST_SEQ_FETCH, CST_SEQ_EXT, CST_SEQ_WRITE, 3);
  endtask
  task automatic test_buffer();
    run_instr(CST_SEQ_FETCH, CST_SEQ_BUF1, CST_SEQ_BUF2, 3);
    check(18'(ctrl.size()), 18'h00002);
    check(ctrl[0], image[9]);
    check(ctrl[1], image[10]);
    check(18'(channelActive), 18'h00001);
  endtask
  // Program words: codes 00, 71, 02, 24, 20, 40, 50:41, 50:44, 50:11 with two buffer words.
  initial begin
    rst_n = 1'b0;
    run = 1'b0;
    operandAddr = 15'h0010;
    accumulatorLower = 18'h2A5A5;
    resultData = 18'h1C3C3;
    image = '{1: 18'h39000, 2: 18'h02000, 3: 18'h14000, 4: 18'h10000, 5: 18'h20000, 6: 18'h28840,
      7: 18'h28900, 8: 18'h28240, 9: 18'h12345, 10: 18'h2ABCD, 16: 18'h0F0F1, default: 18'h00000};
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    run <= 1'b1;
    test_fetch_only();
    test_reads();
    test_writes();
    test_buffer();
    finish_test();
  end
  initial begin
    repeat (3000) @(posedge mclk);
    errors++;
    finish_test();
  end
endmodule
